// [shared/psc_pkg.sv]
// Purpose: shared constants and types of the phase shifter control logic
// Assumes: system clock of 250 MHz, byte addressed register port
// Notes: timing counts are the host minimum times in ns over the clock period

package psc_pkg;

    // ------------------------------------------------------------
    // word and pin layout
    // ------------------------------------------------------------
    localparam int unsigned PHASE_W = 6;
    localparam int unsigned SR_LEN = 6;
    localparam int unsigned PIN_W = 7;
    localparam int unsigned PIN_MODE = 0;
    localparam int unsigned PIN_B1_SDI = 1;
    localparam int unsigned PIN_B2_SCLK = 2;
    localparam int unsigned PIN_B3_LATCH = 3;
    localparam int unsigned PIN_B4 = 4;
    localparam int unsigned PIN_B6 = 6;

    typedef enum logic {
        MODE_PARALLEL = 1'b0,
        MODE_SERIAL = 1'b1
    } psc_mode_e;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned T_SCK_MIN_NS = 100;
    localparam int unsigned T_LES_MIN_NS = 630;
    localparam int unsigned SCK_MIN_CYC = (T_SCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LES_MIN_CYC = (T_LES_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SAMPLE_TOL_CYC = 1;
    localparam int unsigned GAP_W = 8;
    localparam logic [GAP_W-1:0] GAP_RESET = 8'hFF;
    localparam logic [GAP_W-1:0] SCK_GAP_LIM = GAP_W'(SCK_MIN_CYC - 1 - SAMPLE_TOL_CYC);
    localparam logic [GAP_W-1:0] LES_GAP_LIM = GAP_W'(LES_MIN_CYC - 1 - SAMPLE_TOL_CYC);

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_ERR = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_LCNT = 4'hC;
    localparam int unsigned CTRL_CNT_EN_BIT = 0;
    localparam logic CTRL_CNT_EN_RESET = 1'b1;
    localparam int unsigned STATUS_PHASE_LSB = 0;
    localparam int unsigned STATUS_MODE_BIT = 8;
    localparam int unsigned STATUS_CNT_LSB = 12;
    localparam int unsigned ERR_W = 3;
    localparam int unsigned ERR_FAST_BIT = 0;
    localparam int unsigned ERR_CLOSE_BIT = 1;
    localparam int unsigned ERR_SHORT_BIT = 2;
    localparam int unsigned LCNT_W = 16;
    localparam int unsigned BITCNT_W = 3;

endpackage

// [shared/psc_ser_if.sv]
// Purpose: carrier between the pin control and the serial shift register
// Assumes: one clock domain
// Notes: shift_en is a one-cycle pulse per accepted serial clock edge

`timescale 1ns/1ps

interface psc_ser_if #(
    parameter int unsigned W = 6
);
    logic shift_en;
    logic sdi;
    logic [W-1:0] word;
    logic sdo;

    modport ctl (output shift_en, output sdi, input word, input sdo);
    modport shr (input shift_en, input sdi, output word, output sdo);
endinterface

// [logic/psc_pin_sync.sv]
// Purpose: two-flop synchroniser for the asynchronous control pins
// Assumes: every bit is an independent level
// Notes: first stage feeds only the second stage

`timescale 1ns/1ps

module psc_pin_sync #(
    parameter int unsigned W = 7
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule // psc_pin_sync

// [logic/psc_shift_reg.sv]
// Purpose: serial phase word shift register with daisy-chain output
// Assumes: shift_en already masked by mode and latch enable
// Notes: sdo carries the bit pushed out of the last stage

`timescale 1ns/1ps

module psc_shift_reg #(
    parameter int unsigned LEN = 6
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    psc_ser_if.shr sif
);
    logic [LEN-1:0] sr_q;
    logic sdo_q;

    // ------------------------------------------------------------
    // shift, msb first
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sr_q <= '0;
            sdo_q <= 1'b0;
        end else if (sif.shift_en) begin
            sr_q <= {sr_q[LEN-2:0], sif.sdi};
            sdo_q <= sr_q[LEN-1];
        end
    end

    assign sif.word = sr_q;
    assign sif.sdo = sdo_q;
endmodule // psc_shift_reg

// [logic/psc_ctrl_top.sv]
// Purpose: control logic of a 6-bit phase shifter, serial or parallel
// Assumes: pins are asynchronous to clk_i and are synchronised here
// Notes: serial clock edges are found by sampling at 250 MHz
//
// The implementer's own choices: the register offsets and the strobed register port.

`timescale 1ns/1ps

module psc_ctrl_top (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic mode_serial_i,
    input wire logic latch_enable_phase_bit_3_i,
    input wire logic serial_clock_phase_bit_2_i,
    input wire logic serial_data_in_phase_bit_1_i,
    input wire logic phase_bit_4_i,
    input wire logic phase_bit_5_i,
    input wire logic phase_bit_6_i,
    output logic [psc_pkg::PHASE_W-1:0] phase_o,
    output logic serial_data_out_o,
    input wire logic [psc_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [psc_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [psc_pkg::DATA_W-1:0] reg_rdata_o
);
    import psc_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [GAP_W-1:0] sat_inc(input logic [GAP_W-1:0] v);
        sat_inc = (v == GAP_RESET) ? v : v + 8'h01;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;

    assign pin_raw = {phase_bit_6_i,
                      phase_bit_5_i,
                      phase_bit_4_i,
                      latch_enable_phase_bit_3_i,
                      serial_clock_phase_bit_2_i,
                      serial_data_in_phase_bit_1_i,
                      mode_serial_i};

    psc_pin_sync #(
        .W(PIN_W)
    ) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i(pin_raw),
        .q_o(pin_s)
    );

    // ------------------------------------------------------------
    // shared pin decode
    // ------------------------------------------------------------
    psc_mode_e mode;
    logic serial;
    logic latch_s;
    logic sclk_s;
    logic sdi_s;
    logic [PHASE_W-1:0] par_word;

    assign mode = psc_mode_e'(pin_s[PIN_MODE]);
    assign serial = (mode == MODE_SERIAL);
    assign latch_s = pin_s[PIN_B3_LATCH];
    assign sclk_s = pin_s[PIN_B2_SCLK];
    assign sdi_s = pin_s[PIN_B1_SDI];
    assign par_word = {pin_s[PIN_B6:PIN_B4], pin_s[PIN_B3_LATCH:PIN_B1_SDI]};

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    logic sclk_prev_q;
    logic latch_prev_q;
    logic sclk_rise;
    logic latch_rise;
    logic shift_en;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_prev_q <= 1'b0;
            latch_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            latch_prev_q <= latch_s;
        end
    end

    assign sclk_rise = serial & sclk_s & ~sclk_prev_q;
    assign latch_rise = serial & latch_s & ~latch_prev_q;
    assign shift_en = sclk_rise & ~latch_s;

    // ------------------------------------------------------------
    // shift register
    // ------------------------------------------------------------
    psc_ser_if #(.W(PHASE_W)) sif ();

    assign sif.shift_en = shift_en;
    assign sif.sdi = sdi_s;

    psc_shift_reg #(
        .LEN(SR_LEN)
    ) u_shreg (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .sif(sif)
    );

    // ------------------------------------------------------------
    // bit count since last latch
    // ------------------------------------------------------------
    logic [BITCNT_W-1:0] bitcnt_q;
    logic [BITCNT_W-1:0] bitcnt_d;
    logic word_full;

    assign word_full = (bitcnt_q == BITCNT_W'(SR_LEN));
    assign bitcnt_d = latch_rise ? '0 :
                      (shift_en && !word_full) ? bitcnt_q + 3'h1 : bitcnt_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bitcnt_q <= '0;
        end else begin
            bitcnt_q <= bitcnt_d;
        end
    end

    // ------------------------------------------------------------
    // active phase state
    // ------------------------------------------------------------
    logic [PHASE_W-1:0] phase_q;
    logic [PHASE_W-1:0] phase_d;
    logic sdo_q;

    assign phase_d = !serial ? par_word :
                     latch_rise ? sif.word :
                     phase_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_q <= '0;
            sdo_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            sdo_q <= serial & sif.sdo;
        end
    end

    assign phase_o = phase_q;
    assign serial_data_out_o = sdo_q;

    // ------------------------------------------------------------
    // host timing watch
    // ------------------------------------------------------------
    logic [GAP_W-1:0] sck_gap_q;
    logic [GAP_W-1:0] les_gap_q;
    logic fast_ev;
    logic close_ev;
    logic short_ev;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_gap_q <= GAP_RESET;
            les_gap_q <= GAP_RESET;
        end else begin
            sck_gap_q <= sclk_rise ? '0 : sat_inc(sck_gap_q);
            les_gap_q <= latch_rise ? '0 : sat_inc(les_gap_q);
        end
    end

    assign fast_ev = sclk_rise & (sck_gap_q < SCK_GAP_LIM);
    assign close_ev = latch_rise & (les_gap_q < LES_GAP_LIM);
    assign short_ev = latch_rise & ~word_full;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic wr_err;
    logic cnt_en_q;
    logic [ERR_W-1:0] err_q;
    logic [ERR_W-1:0] err_set;
    logic [ERR_W-1:0] err_clr;
    logic [LCNT_W-1:0] lcnt_q;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] rdata_q;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_CTRL);
    assign wr_err = reg_wr_i && (reg_addr_i == ADDR_ERR);
    assign err_set = {short_ev, close_ev, fast_ev};
    assign err_clr = wr_err ? reg_wdata_i[ERR_W-1:0] : '0;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_en_q <= CTRL_CNT_EN_RESET;
            err_q <= '0;
            lcnt_q <= '0;
        end else begin
            if (wr_ctrl) begin
                cnt_en_q <= reg_wdata_i[CTRL_CNT_EN_BIT];
            end
            err_q <= (err_q & ~err_clr) | err_set;
            if (latch_rise && cnt_en_q) begin
                lcnt_q <= lcnt_q + 16'h0001;
            end
        end
    end

    assign status_word = DATA_W'({bitcnt_q, 3'h0, serial, 2'h0, phase_q});

    assign rd_mux = (reg_addr_i == ADDR_CTRL) ? DATA_W'(cnt_en_q) :
                    (reg_addr_i == ADDR_STATUS) ? status_word :
                    (reg_addr_i == ADDR_ERR) ? DATA_W'(err_q) :
                    (reg_addr_i == ADDR_LCNT) ? DATA_W'(lcnt_q) :
                    '0;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_rd_i ? rd_mux : '0;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_shift;
        serial && sclk_rise && !latch_s;
    endsequence

    sequence s_full_latch;
        word_full ##0 latch_rise;
    endsequence

    a_serial_shift: assert property (
        s_shift |=> sif.word == {$past(sif.word[SR_LEN-2:0]), $past(sdi_s)})
        else $error("shift register did not take serial data");

    a_serial_select: assert property (
        (mode_serial_i ##2 (serial && sclk_rise && !latch_s)) |=> bitcnt_q != 3'h0)
        else $error("serial clock edge not counted in serial mode");

    a_latch_load: assert property (
        s_full_latch |=> (phase_q == $past(sif.word)) && (bitcnt_q == 3'h0))
        else $error("latch edge did not load the phase state");

    a_latch_mask: assert property (
        latch_s |=> $stable(sif.word) && ($past(latch_rise) || $stable(bitcnt_q)))
        else $error("shift register moved while latch enable high");

    a_sdo_delay: assert property (
        (s_shift ##1 serial) |=> serial_data_out_o == $past(sif.word[SR_LEN-1], 2))
        else $error("serial out does not carry the oldest bit");

    a_parallel_off: assert property (
        !serial |=> $stable(sif.word) && !serial_data_out_o)
        else $error("serial port active in parallel mode");

    a_serial_hold: assert property (
        serial && !latch_rise |=> $stable(phase_o))
        else $error("phase changed without a latch edge");

    a_parallel_follow: assert property (
        !serial |=> phase_o == $past(par_word))
        else $error("phase does not follow parallel inputs");

    a_fast_flag: assert property (
        fast_ev |=> err_q[ERR_FAST_BIT] ##1 (err_q[ERR_FAST_BIT] || $past(wr_err)))
        else $error("fast serial clock not flagged");

    a_close_flag: assert property (
        close_ev |=> err_q[ERR_CLOSE_BIT])
        else $error("close latch pulses not flagged");

    a_read_once: assert property (
        !reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data stands outside its cycle");

endmodule // psc_ctrl_top

// [tb/psc_host_model.sv]
// Purpose: host controller model driving the phase shifter control pins
// Assumes: pins are asynchronous to the device clock
// Notes: serial clock stands low outside frames, released data shows the inverse

`timescale 1ns/1ps

module psc_host_model (
    output logic mode_serial_o,
    output logic latch_enable_o,
    output logic sclk_o,
    output logic sdi_o,
    output logic [2:0] hi_bits_o,
    input wire logic sdo_i
);
    logic [11:0] cap;

    initial begin
        mode_serial_o = 1'b0;
        latch_enable_o = 1'b0;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
        hi_bits_o = 3'h0;
        cap = 12'h000;
    end

    // ------------------------------------------------------------
    // pin tasks
    // ------------------------------------------------------------
    // parallel word straight onto the six pins
    task automatic par(input logic [5:0] w);
        mode_serial_o = 1'b0;
        {hi_bits_o, latch_enable_o, sclk_o, sdi_o} = w;
        #60;
    endtask

    // shared pins parked before the mode flips
    task automatic to_serial();
        {latch_enable_o, sclk_o, sdi_o} = 3'h0;
        #40;
        mode_serial_o = 1'b1;
        #60;
    endtask

    // data changes while the clock is low, chain output taken at each fall
    task automatic send(input logic [11:0] bits, input int n, input int half);
        for (int i = n - 1; i >= 0; i--) begin
            sdi_o = bits[i];
            #half; // half period chosen by caller
            sclk_o = 1'b1;
            #half;
            sclk_o = 1'b0;
            cap = {cap[10:0], sdo_i};
        end
        sdi_o = ~sdi_o;
        #half;
    endtask

    // latch pulse, optional clock pulses while it is high
    task automatic latch(input int gap, input int clocks);
        latch_enable_o = 1'b1;
        #40;
        repeat (clocks) begin
            sdi_o = ~sdi_o;
            #64;
            sclk_o = 1'b1;
            #64;
            sclk_o = 1'b0;
        end
        #40;
        latch_enable_o = 1'b0;
        #gap; // caller keeps the spacing
    endtask
endmodule // psc_host_model

// [tb/psc_ctrl_top_tb.sv]
// Purpose: self-checking bench of the phase shifter control logic
// Assumes: host model drives the pins, bench drives the register port
// Notes: serial frames at 128 ns period, one fast frame at 32 ns

`timescale 1ns/1ps

module psc_ctrl_top_tb;
    import psc_pkg::*;

    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic mode, latch_en, sclk, sdi, sdo, wr, rd;
    logic [2:0] hi;
    logic [PHASE_W-1:0] phase_o;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [5:0] tbl [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3F};
    int checked = 0;
    int bad_count = 0;

    always #2 clk_i = ~clk_i;

    psc_host_model host_i (.mode_serial_o(mode), .latch_enable_o(latch_en), .sclk_o(sclk),
        .sdi_o(sdi),
        .hi_bits_o(hi), .sdo_i(sdo));

    psc_ctrl_top psc_ctrl_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .mode_serial_i(mode),
        .latch_enable_phase_bit_3_i(latch_en), .serial_clock_phase_bit_2_i(sclk),
        .serial_data_in_phase_bit_1_i(sdi), .phase_bit_4_i(hi[0]), .phase_bit_5_i(hi[1]),
        .phase_bit_6_i(hi[2]), .phase_o(phase_o), .serial_data_out_o(sdo),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata));

    // ------------------------------------------------------------
    // register port and compare tasks
    // ------------------------------------------------------------
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_reg(input string name, input logic [ADDR_W-1:0] a,
        input logic [31:0] exp);
        logic [31:0] d;
        reg_rd(a, d);
        chk_val(name, exp, d);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        addr <= '0;
        wdata <= '0;
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk_reg("ctrl reset", ADDR_CTRL, 32'h1);
        chk_reg("err reset", ADDR_ERR, 32'h0);
        @(posedge clk_i);
        #1;
        chk_val("rdata idle", 32'h0, rdata);
        $display("test reset done");

        for (int i = 0; i < 8; i++) begin
            host_i.par(tbl[i]);
            chk_val("par phase", 32'(tbl[i]), 32'(phase_o));
            chk_val("par sdo", 32'h0, 32'(sdo));
        end
        chk_reg("par status", ADDR_STATUS, 32'h3F);
        $display("test parallel done");

        host_i.to_serial();
        host_i.send(12'h02D, 6, 64);
        chk_val("hold phase", 32'h38, 32'(phase_o));
        chk_reg("shift status", ADDR_STATUS, 32'h6138);
        host_i.latch(700, 0);
        chk_val("latch phase", 32'h2D, 32'(phase_o));
        chk_reg("err clean", ADDR_ERR, 32'h0);
        $display("test serial done");

        fork
            host_i.latch(700, 4);
            begin
                #300;
                chk_reg("le high status", ADDR_STATUS, 32'h012D);
            end
        join
        chk_reg("mask status", ADDR_STATUS, 32'h012D);
        chk_reg("mask err", ADDR_ERR, 32'h4);
        reg_wr(ADDR_ERR, 32'h7);
        chk_reg("err clear", ADDR_ERR, 32'h0);
        $display("test mask done");

        host_i.send({6'h35, 6'h0A}, 12, 64);
        chk_val("chain out", 32'hB75, 32'(host_i.cap));
        host_i.latch(700, 0);
        chk_val("chain phase", 32'h0A, 32'(phase_o));
        $display("test chain done");

        host_i.send(12'h013, 6, 16);
        host_i.latch(700, 0);
        chk_val("fast phase", 32'h13, 32'(phase_o));
        chk_reg("fast err", ADDR_ERR, 32'h1);
        reg_wr(ADDR_ERR, 32'h1);
        host_i.send(12'h005, 3, 64);
        host_i.latch(100, 0);
        host_i.latch(700, 0);
        chk_val("short phase", 32'h1D, 32'(phase_o));
        chk_reg("close err", ADDR_ERR, 32'h6);
        $display("test errors done");

        reg_wr(ADDR_CTRL, 32'h0);
        chk_reg("ctrl off", ADDR_CTRL, 32'h0);
        host_i.send(12'h02A, 6, 64);
        host_i.latch(700, 0);
        reg_wr(ADDR_LCNT, 32'h0);
        reg_wr(ADDR_STATUS, 32'h0);
        reg_wr(4'h2, 32'hFFFF_FFFF);
        chk_reg("lcnt held", ADDR_LCNT, 32'h6);
        chk_reg("status ro", ADDR_STATUS, 32'h012A);
        chk_reg("unmapped", 4'h2, 32'h0);
        $display("test registers done");
        summarize();
    end

    initial begin
        #100us;
        bad_count++;
        $display("FAIL watchdog expected done seen hang");
        summarize();
    end
endmodule // psc_ctrl_top_tb
